// ### design/dipa_top.v
// Notes on behaviour
// RULE_01 - Host writes entries only on-hook in command mode; others may be dropped.
// RULE_02 - Each entry has a 16-bit address and holds 14 data bits.
// RULE_03 - Host loads entry address first, then data for that address.
// RULE_04 - Select 0x00: low port loads address [7:0], high port [15:8].
// RULE_05 - Select 0x01: low and high ports load data bytes for loaded address.
// RULE_06 - High data byte gives upper 6 bits, low byte lower 8 bits.
// RULE_07 - Port meaning depends on select value and on read versus write.
// RULE_08 - Select 0x02 low read: bit7 available, bit6 detected, bits4:0 tone code.
// RULE_09 - Select 0x02 low write: bits6:3 digit to send, bits2:0 tone type.
// RULE_10 - Select 0x02 high write: bit7 squaring, bit6 cascade disable.
// RULE_11 - High write bits 4..0 enable reporting of tone classes.
// RULE_12 - Host writes no unlisted addresses nor out-of-range values.
// RULE_13 - User tone frequency equals entry value times 9600/512 Hz.
// RULE_14 - Detector centres encode 8192 cos of 2 pi f over 9600.
// RULE_15 - Carrier valid at on-threshold, invalid below off-threshold.
// RULE_16 - Answer tone valid at on-threshold, invalid below off-threshold.
// RULE_17 - Tone generation level entry sets amplitude of generated tones.
// RULE_18 - One sensitivity entry serves all four frequency detectors.
// RULE_19 - Call progress threshold comes from its own entry.
// RULE_20 - Transmit level entry scales modem full-scale transmit level.
// RULE_21 - Touch-tone high level and twist come from their own entries.
// RULE_22 - Tone type 110b sends user tone at user frequency, generation level.
// RULE_23 - Status reports only highest-priority enabled detected tone.
// RULE_24 - Low data byte write commits assembled value after high byte write.
`timescale 1ns/100ps
`include "dipa_defs.vh"

module dipa_top #(
  parameter [4:0] CODE_ANSWER  = 5'h01,
  parameter [4:0] CODE_V23     = 5'h02,
  parameter [4:0] CODE_USER12  = 5'h03,
  parameter [4:0] CODE_USER34  = 5'h04,
  parameter [4:0] CODE_TOUCH   = 5'h10
) (
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  input  wire        onhook_command_in,
  input  wire        sample_tick_in,
  input  wire [4:0]  tone_hits_in,
  input  wire [3:0]  touch_digit_in,
  input  wire [13:0] carrier_level_in,
  input  wire [13:0] answer_level_in,
  output reg  [13:0] transmit_full_scale_level_out,
  output reg  [13:0] dual_tone_high_level_out,
  output reg  [13:0] dual_tone_twist_out,
  output reg  [13:0] user_tone_frequency_out,
  output reg  [13:0] progress_detect_level_out,
  output reg  [13:0] freq_detector_one_centre_out,
  output reg  [13:0] freq_detector_two_centre_out,
  output reg  [13:0] freq_detector_three_centre_out,
  output reg  [13:0] freq_detector_four_centre_out,
  output reg  [13:0] tone_generation_level_out,
  output reg  [13:0] freq_detector_sensitivity_out,
  output reg  [3:0]  touch_tone_digit_out,
  output reg  [2:0]  tone_type_field_out,
  output reg         square_enable_out,
  output reg         cascade_disable_out,
  output reg  [4:0]  report_enable_out,
  output reg         user_tone_active_out,
  output reg  [13:0] user_tone_amplitude_out,
  output reg  [8:0]  user_tone_phase_out,
  output reg         carrier_valid_out,
  output reg         answer_valid_out
);

  reg  [7:0]  indirect_port_select;
  reg  [7:0]  entry_address_low;
  reg  [7:0]  entry_address_high;
  reg  [5:0]  entry_data_high;
  reg         high_pending;
  reg  [13:0] bank [0:`DIPA_ENTRIES-1];
  reg         data_available;
  reg  [4:0]  last_code;
  reg  [7:0]  next_rdata;
  reg  [4:0]  next_code;
  reg         next_found;

  wire        wr_low  = reg_wr_in && (reg_addr_in == `DIPA_PORT_LOW_ADDR);
  wire        wr_high = reg_wr_in && (reg_addr_in == `DIPA_PORT_HIGH_ADDR);
  wire        wr_sel  = reg_wr_in && (reg_addr_in == `DIPA_PORT_SELECT_ADDR);
  wire        rd_low  = reg_rd_in && (reg_addr_in == `DIPA_PORT_LOW_ADDR);
  wire        in_addr_view = (indirect_port_select == `DIPA_VIEW_ADDRESS);
  wire        in_data_view = (indirect_port_select == `DIPA_VIEW_DATA);
  wire        in_tone_view = (indirect_port_select == `DIPA_VIEW_TONE);
  wire [15:0] entry_address = {entry_address_high, entry_address_low};
  wire [3:0]  entry_index;
  wire [13:0] assembled = {entry_data_high, reg_wdata_in};
  wire [4:0]  live_hits = tone_hits_in & report_enable_out;
  wire        status_read = rd_low && in_tone_view;

  // Address decode of the parameter set
  function [3:0] dipa_index;
    input [15:0] addr;
    begin
      case (addr)
        `DIPA_TRANSMIT_FULL_SCALE_LEVEL:  dipa_index = 4'h0;
        `DIPA_DUAL_TONE_HIGH_LEVEL:       dipa_index = 4'h1;
        `DIPA_DUAL_TONE_TWIST:            dipa_index = 4'h2;
        `DIPA_USER_TONE_FREQUENCY:        dipa_index = 4'h3;
        `DIPA_PROGRESS_DETECT_LEVEL:      dipa_index = 4'h4;
        `DIPA_FREQ_DETECTOR_ONE_CENTRE:   dipa_index = 4'h5;
        `DIPA_FREQ_DETECTOR_TWO_CENTRE:   dipa_index = 4'h6;
        `DIPA_FREQ_DETECTOR_THREE_CENTRE: dipa_index = 4'h7;
        `DIPA_FREQ_DETECTOR_FOUR_CENTRE:  dipa_index = 4'h8;
        `DIPA_TONE_GENERATION_LEVEL:      dipa_index = 4'h9;
        `DIPA_FREQ_DETECTOR_SENSITIVITY:  dipa_index = 4'ha;
        `DIPA_CARRIER_ON_THRESHOLD:       dipa_index = 4'hb;
        `DIPA_CARRIER_OFF_THRESHOLD:      dipa_index = 4'hc;
        `DIPA_ANSWER_ON_THRESHOLD:        dipa_index = 4'hd;
        `DIPA_ANSWER_OFF_THRESHOLD:       dipa_index = 4'he;
        default:                          dipa_index = `DIPA_NO_ENTRY;
      endcase
    end
  endfunction

  function [13:0] dipa_default;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    dipa_default = `DIPA_TRANSMIT_FULL_SCALE_LEVEL_RST;
        4'h1:    dipa_default = `DIPA_DUAL_TONE_HIGH_LEVEL_RST;
        4'h2:    dipa_default = `DIPA_DUAL_TONE_TWIST_RST;
        4'h3:    dipa_default = `DIPA_USER_TONE_FREQUENCY_RST;
        4'h4:    dipa_default = `DIPA_PROGRESS_DETECT_LEVEL_RST;
        4'h5:    dipa_default = `DIPA_FREQ_DETECTOR_ONE_CENTRE_RST;
        4'h6:    dipa_default = `DIPA_FREQ_DETECTOR_TWO_CENTRE_RST;
        4'h7:    dipa_default = `DIPA_FREQ_DETECTOR_THREE_CENTRE_RST;
        4'h8:    dipa_default = `DIPA_FREQ_DETECTOR_FOUR_CENTRE_RST;
        4'h9:    dipa_default = `DIPA_TONE_GENERATION_LEVEL_RST;
        4'ha:    dipa_default = `DIPA_FREQ_DETECTOR_SENSITIVITY_RST;
        4'hb:    dipa_default = `DIPA_CARRIER_ON_THRESHOLD_RST;
        4'hc:    dipa_default = `DIPA_CARRIER_OFF_THRESHOLD_RST;
        4'hd:    dipa_default = `DIPA_ANSWER_ON_THRESHOLD_RST;
        4'he:    dipa_default = `DIPA_ANSWER_OFF_THRESHOLD_RST;
        default: dipa_default = 14'h0000;
      endcase
    end
  endfunction

  assign entry_index = dipa_index(entry_address);

  // Select register and address bytes
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      indirect_port_select <= `DIPA_PORT_SELECT_RST;
      entry_address_low    <= 8'h00;
      entry_address_high   <= 8'h00;
    end else begin
      if (wr_sel)
        indirect_port_select <= reg_wdata_in;
      if (wr_low && in_addr_view)
        entry_address_low <= reg_wdata_in;          // [RULE_04]
      if (wr_high && in_addr_view)
        entry_address_high <= reg_wdata_in;         // [RULE_04]
    end
  end

  // Data assembly; a fresh address forgets a half-written value
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      entry_data_high <= 6'h00;
      high_pending    <= 1'b0;
    end else begin
      if (wr_high && in_data_view) begin
        entry_data_high <= reg_wdata_in[5:0];       // [RULE_05] [RULE_06]
        high_pending    <= 1'b1;
      end else if ((wr_low && in_data_view) || (reg_wr_in && in_addr_view)) begin
        high_pending <= 1'b0;                       // [RULE_03]
      end
    end
  end

  // Parameter bank
  genvar gi;
  generate
    for (gi = 0; gi < `DIPA_ENTRIES; gi = gi + 1) begin : g_entry
      localparam [3:0] ENTRY_IDX = gi;
      always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
          bank[gi] <= dipa_default(ENTRY_IDX);
        else if (wr_low && in_data_view && high_pending && onhook_command_in
                 && (entry_index == ENTRY_IDX))
          bank[gi] <= assembled;                    // [RULE_02] [RULE_24] [RULE_01]
      end
    end
  endgenerate

  // Bank outputs feeding the signal path
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      transmit_full_scale_level_out  <= `DIPA_TRANSMIT_FULL_SCALE_LEVEL_RST;
      dual_tone_high_level_out       <= `DIPA_DUAL_TONE_HIGH_LEVEL_RST;
      dual_tone_twist_out            <= `DIPA_DUAL_TONE_TWIST_RST;
      user_tone_frequency_out        <= `DIPA_USER_TONE_FREQUENCY_RST;
      progress_detect_level_out      <= `DIPA_PROGRESS_DETECT_LEVEL_RST;
      freq_detector_one_centre_out   <= `DIPA_FREQ_DETECTOR_ONE_CENTRE_RST;
      freq_detector_two_centre_out   <= `DIPA_FREQ_DETECTOR_TWO_CENTRE_RST;
      freq_detector_three_centre_out <= `DIPA_FREQ_DETECTOR_THREE_CENTRE_RST;
      freq_detector_four_centre_out  <= `DIPA_FREQ_DETECTOR_FOUR_CENTRE_RST;
      tone_generation_level_out      <= `DIPA_TONE_GENERATION_LEVEL_RST;
      freq_detector_sensitivity_out  <= `DIPA_FREQ_DETECTOR_SENSITIVITY_RST;
    end else begin
      transmit_full_scale_level_out  <= bank[0];    // [RULE_20]
      dual_tone_high_level_out       <= bank[1];    // [RULE_21]
      dual_tone_twist_out            <= bank[2];    // [RULE_21]
      user_tone_frequency_out        <= bank[3];
      progress_detect_level_out      <= bank[4];    // [RULE_19]
      freq_detector_one_centre_out   <= bank[5];    // [RULE_14]
      freq_detector_two_centre_out   <= bank[6];    // [RULE_14]
      freq_detector_three_centre_out <= bank[7];    // [RULE_14]
      freq_detector_four_centre_out  <= bank[8];    // [RULE_14]
      tone_generation_level_out      <= bank[9];    // [RULE_17]
      freq_detector_sensitivity_out  <= bank[10];   // [RULE_18]
    end
  end

  // Tone transmit and reporting views, write side only
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      touch_tone_digit_out <= 4'h0;
      tone_type_field_out  <= 3'h0;
      square_enable_out    <= 1'b0;
      cascade_disable_out  <= 1'b0;
      report_enable_out    <= 5'h00;
    end else begin
      if (wr_low && in_tone_view) begin
        touch_tone_digit_out <= reg_wdata_in[`DIPA_TX_DIGIT_HI:`DIPA_TX_DIGIT_LO]; // [RULE_09]
        tone_type_field_out  <= reg_wdata_in[`DIPA_TX_TYPE_HI:`DIPA_TX_TYPE_LO];   // [RULE_09]
      end
      if (wr_high && in_tone_view) begin
        square_enable_out   <= reg_wdata_in[`DIPA_RPT_SQUARE_BIT];   // [RULE_10]
        cascade_disable_out <= reg_wdata_in[`DIPA_RPT_CASCADE_BIT];  // [RULE_10]
        report_enable_out   <= reg_wdata_in[`DIPA_RPT_ENABLE_HI:0];  // [RULE_11]
      end
    end
  end

  // Priority encoder: answer, V.23, touch-tone, user 1/2, user 3/4
  always @* begin
    next_found = 1'b1;
    next_code  = 5'h00;
    if (live_hits[1])
      next_code = CODE_ANSWER;                      // [RULE_23]
    else if (live_hits[2])
      next_code = CODE_V23;                         // [RULE_23]
    else if (live_hits[0])
      next_code = CODE_TOUCH | {1'b0, touch_digit_in};
    else if (live_hits[3])
      next_code = CODE_USER12;
    else if (live_hits[4])
      next_code = CODE_USER34;
    else
      next_found = 1'b0;
  end

  // Sticky availability; a new detection beats the clearing read
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_available <= 1'b0;
      last_code      <= 5'h00;
    end else begin
      if (next_found && (!data_available || next_code != last_code)) begin
        data_available <= 1'b1;
        last_code      <= next_code;
      end else if (status_read) begin
        data_available <= 1'b0;
      end
    end
  end

  // Read views; write-only ports read as zero
  always @* begin
    next_rdata = 8'h00;
    if (reg_addr_in == `DIPA_PORT_SELECT_ADDR)
      next_rdata = indirect_port_select;
    else if (status_read) begin
      next_rdata[`DIPA_STAT_AVAIL_BIT] = data_available;    // [RULE_07] [RULE_08]
      next_rdata[`DIPA_STAT_DET_BIT]   = next_found;        // [RULE_08]
      next_rdata[4:0]                  = last_code;         // [RULE_08]
    end
  end

  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= next_rdata;
  end

  // User tone: 9-bit phase wraps at the entry value times the sample rate over 512
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      user_tone_phase_out     <= 9'h000;
      user_tone_active_out    <= 1'b0;
      user_tone_amplitude_out <= 14'h0000;
    end else begin
      user_tone_active_out <= (tone_type_field_out == `DIPA_USER_TONE_TYPE); // [RULE_22]
      user_tone_amplitude_out <= (tone_type_field_out == `DIPA_USER_TONE_TYPE) ?
                                 bank[9] : 14'h0000;                         // [RULE_17]
      // Phase follows the registered flag and step, so it never runs ahead of them
      if (!user_tone_active_out)
        user_tone_phase_out <= 9'h000;
      else if (sample_tick_in)
        user_tone_phase_out <= user_tone_phase_out + user_tone_frequency_out[8:0]; // [RULE_13]
    end
  end

  // Level hysteresis
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      carrier_valid_out <= 1'b0;
      answer_valid_out  <= 1'b0;
    end else begin
      if (carrier_level_in >= bank[11])
        carrier_valid_out <= 1'b1;                  // [RULE_15]
      else if (carrier_level_in < bank[12])
        carrier_valid_out <= 1'b0;                  // [RULE_15]
      if (answer_level_in >= bank[13])
        answer_valid_out <= 1'b1;                   // [RULE_16]
      else if (answer_level_in < bank[14])
        answer_valid_out <= 1'b0;                   // [RULE_16]
    end
  end

endmodule

// ### design/dipa_defs.vh
`ifndef DIPA_DEFS_VH
`define DIPA_DEFS_VH

// Controller-side byte register addresses
`define DIPA_PORT_LOW_ADDR     8'he5
`define DIPA_PORT_HIGH_ADDR    8'he6
`define DIPA_PORT_SELECT_ADDR  8'he8
`define DIPA_PORT_SELECT_RST   8'h00

// Port select views
`define DIPA_VIEW_ADDRESS      8'h00
`define DIPA_VIEW_DATA         8'h01
`define DIPA_VIEW_TONE         8'h02

// Entry geometry
`define DIPA_ADDR_W            16
`define DIPA_DATA_W            14
`define DIPA_DATA_HI_W         6
`define DIPA_ENTRIES           15
`define DIPA_NO_ENTRY          4'hf

// Parameter entry addresses
`define DIPA_TRANSMIT_FULL_SCALE_LEVEL   16'h0002
`define DIPA_DUAL_TONE_HIGH_LEVEL        16'h0003
`define DIPA_DUAL_TONE_TWIST             16'h0004
`define DIPA_USER_TONE_FREQUENCY         16'h0005
`define DIPA_PROGRESS_DETECT_LEVEL       16'h0006
`define DIPA_FREQ_DETECTOR_ONE_CENTRE    16'h0007
`define DIPA_FREQ_DETECTOR_TWO_CENTRE    16'h0008
`define DIPA_FREQ_DETECTOR_THREE_CENTRE  16'h0009
`define DIPA_FREQ_DETECTOR_FOUR_CENTRE   16'h000a
`define DIPA_TONE_GENERATION_LEVEL       16'h000b
`define DIPA_FREQ_DETECTOR_SENSITIVITY   16'h000e
`define DIPA_CARRIER_ON_THRESHOLD        16'h0024
`define DIPA_CARRIER_OFF_THRESHOLD       16'h0025
`define DIPA_ANSWER_ON_THRESHOLD         16'h0026
`define DIPA_ANSWER_OFF_THRESHOLD        16'h0027

// Reset values
`define DIPA_TRANSMIT_FULL_SCALE_LEVEL_RST   14'h1000
`define DIPA_DUAL_TONE_HIGH_LEVEL_RST        14'h1304
`define DIPA_DUAL_TONE_TWIST_RST             14'h0ccd
`define DIPA_USER_TONE_FREQUENCY_RST         14'h005b
`define DIPA_PROGRESS_DETECT_LEVEL_RST       14'h1000
`define DIPA_FREQ_DETECTOR_ONE_CENTRE_RST    14'h137b
`define DIPA_FREQ_DETECTOR_TWO_CENTRE_RST    14'h0218
`define DIPA_FREQ_DETECTOR_THREE_CENTRE_RST  14'h137b
`define DIPA_FREQ_DETECTOR_FOUR_CENTRE_RST   14'h0218
`define DIPA_TONE_GENERATION_LEVEL_RST       14'h0b50
`define DIPA_FREQ_DETECTOR_SENSITIVITY_RST   14'h1000
`define DIPA_CARRIER_ON_THRESHOLD_RST        14'h0a3c
`define DIPA_CARRIER_OFF_THRESHOLD_RST       14'h0ce4
`define DIPA_ANSWER_ON_THRESHOLD_RST         14'h0043
`define DIPA_ANSWER_OFF_THRESHOLD_RST        14'h0025

// Tone view field positions
`define DIPA_STAT_AVAIL_BIT    7
`define DIPA_STAT_DET_BIT      6
`define DIPA_TX_DIGIT_HI       6
`define DIPA_TX_DIGIT_LO       3
`define DIPA_TX_TYPE_HI        2
`define DIPA_TX_TYPE_LO        0
`define DIPA_RPT_SQUARE_BIT    7
`define DIPA_RPT_CASCADE_BIT   6
`define DIPA_RPT_ENABLE_HI     4
`define DIPA_USER_TONE_TYPE    3'h6

// Tone phase: 9 bits, so the step is the sample rate over 512
`define DIPA_PHASE_W           9

`endif

// ### verification/dipa_chk_sva.sv
`timescale 1ns/100ps
`include "dipa_defs.vh"
module dipa_chk (
  input wire        sys_clk_in,
  input wire        sys_rst_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [7:0]  reg_addr_in,
  input wire [7:0]  reg_wdata_in,
  input wire        sample_tick_in,
  input wire [7:0]  reg_rdata_out,
  input wire [13:0] user_tone_frequency_out,
  input wire [13:0] tone_generation_level_out,
  input wire [3:0]  touch_tone_digit_out,
  input wire [2:0]  tone_type_field_out,
  input wire        square_enable_out,
  input wire        cascade_disable_out,
  input wire [4:0]  report_enable_out,
  input wire        user_tone_active_out,
  input wire [13:0] user_tone_amplitude_out,
  input wire [8:0]  user_tone_phase_out
);
  logic [7:0] sel;
  wire        lo = reg_addr_in == `DIPA_PORT_LOW_ADDR;
  wire        tone = sel == `DIPA_VIEW_TONE;
  wire        sel_a = reg_addr_in == `DIPA_PORT_SELECT_ADDR;
  wire        wr_lo = reg_wr_in && lo && tone;
  wire        wr_hi = reg_wr_in && reg_addr_in == `DIPA_PORT_HIGH_ADDR && tone;
  wire        rd_zero = reg_rd_in && !sel_a && !(lo && tone);
  // Shadow of the select register, so views can be judged
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    if (sys_rst_in) sel <= `DIPA_PORT_SELECT_RST;
    else if (reg_wr_in && sel_a) sel <= reg_wdata_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RD_ZERO: assert property (rd_zero |=> reg_rdata_out == 8'h00)
    else $error("read of a write-only view not zero");
  AST_RD_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  AST_SEL_READ: assert property (reg_rd_in && sel_a |=> reg_rdata_out == $past(sel))
    else $error("select readback wrong");
  AST_STAT_RSVD: assert property (reg_rd_in && lo && tone |=> !reg_rdata_out[5])
    else $error("status reserved bit set");
  AST_TX_VIEW: assert property (wr_lo |=>
    {touch_tone_digit_out, tone_type_field_out} == $past(reg_wdata_in[6:0]))
    else $error("transmit view fields wrong");
  AST_RPT_VIEW: assert property (wr_hi |=> {square_enable_out, cascade_disable_out,
    report_enable_out} == {$past(reg_wdata_in[7:6]), $past(reg_wdata_in[4:0])})
    else $error("reporting view fields wrong");
  AST_ACTIVE: assert property (user_tone_active_out ==
    ($past(tone_type_field_out) == `DIPA_USER_TONE_TYPE))
    else $error("user tone active does not follow tone type");
  AST_AMP: assert property (user_tone_active_out && $past(user_tone_active_out) &&
    $stable(tone_generation_level_out) |-> user_tone_amplitude_out == tone_generation_level_out)
    else $error("user tone amplitude wrong");
  AST_PHASE_STEP: assert property (sample_tick_in && user_tone_active_out |=>
    user_tone_phase_out == $past(user_tone_phase_out) + $past(user_tone_frequency_out[8:0]))
    else $error("phase step wrong");
  AST_PHASE_IDLE: assert property (!user_tone_active_out && $past(!user_tone_active_out)
    |-> user_tone_phase_out == 9'h000 && user_tone_amplitude_out == 14'h0000)
    else $error("idle tone not silent");
endmodule
bind dipa_top dipa_chk i_chk (.*);

// ### verification/tb.sv
`timescale 1ns/100ps
`include "dipa_defs.vh"
module tb;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        onhook_command_in = 1'b1;
  logic        sample_tick_in = 1'b0;
  logic [4:0]  tone_hits_in = 5'h00;
  logic [3:0]  touch_digit_in = 4'h0;
  logic [13:0] carrier_level_in = 14'h0000;
  logic [13:0] answer_level_in = 14'h0000;
  wire  [7:0]  reg_rdata_out;
  wire  [13:0] transmit_full_scale_level_out, dual_tone_high_level_out, dual_tone_twist_out;
  wire  [13:0] user_tone_frequency_out, progress_detect_level_out, freq_detector_one_centre_out;
  wire  [13:0] freq_detector_two_centre_out, freq_detector_three_centre_out;
  wire  [13:0] freq_detector_four_centre_out, tone_generation_level_out;
  wire  [13:0] freq_detector_sensitivity_out, user_tone_amplitude_out;
  wire  [3:0]  touch_tone_digit_out;
  wire  [2:0]  tone_type_field_out;
  wire  [4:0]  report_enable_out;
  wire  [8:0]  user_tone_phase_out;
  wire         square_enable_out, cascade_disable_out, user_tone_active_out;
  wire         carrier_valid_out, answer_valid_out;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycle_cnt = 0;
  logic [7:0]  rd_val;
  logic [15:0] ent [11] = '{16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
                            16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000e};
  logic [13:0] dflt [11] = '{14'h1000, 14'h1304, 14'h0ccd, 14'h005b, 14'h1000, 14'h137b,
                             14'h0218, 14'h137b, 14'h0218, 14'h0b50, 14'h1000};

  dipa_top i_dut (.*);

  always #20 sys_clk_in = ~sys_clk_in;

  function automatic logic [13:0] bank_out(input int i);
    case (i)
      0: return transmit_full_scale_level_out;
      1: return dual_tone_high_level_out;
      2: return dual_tone_twist_out;
      3: return user_tone_frequency_out;
      4: return progress_detect_level_out;
      5: return freq_detector_one_centre_out;
      6: return freq_detector_two_centre_out;
      7: return freq_detector_three_centre_out;
      8: return freq_detector_four_centre_out;
      9: return tone_generation_level_out;
      default: return freq_detector_sensitivity_out;
    endcase
  endfunction

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      give_verdict;
    end
  end

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge sys_clk_in);
    reg_rd_in = 1'b0;
    @(negedge sys_clk_in);
    rd_val = reg_rdata_out;
  endtask

  // High data byte carries junk in bits 7:6, which must be dropped
  task automatic put_entry(input logic [15:0] a, input logic [13:0] d);
    wr(`DIPA_PORT_SELECT_ADDR, `DIPA_VIEW_ADDRESS);
    wr(`DIPA_PORT_HIGH_ADDR, a[15:8]);
    wr(`DIPA_PORT_LOW_ADDR, a[7:0]);
    wr(`DIPA_PORT_SELECT_ADDR, `DIPA_VIEW_DATA);
    wr(`DIPA_PORT_HIGH_ADDR, {2'b11, d[13:8]});
    wr(`DIPA_PORT_LOW_ADDR, d[7:0]);
    repeat (2) @(negedge sys_clk_in);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 11; i++)
      check_val("bank default", dflt[i], bank_out(i));
    check_val("views", 16'h0000, {report_enable_out, tone_type_field_out});
  endtask

  task automatic t_bank;
    for (int i = 0; i < 11; i++)
      put_entry(ent[i], 14'h3fff - 14'h0123 * i[13:0]);
    for (int i = 0; i < 11; i++)
      check_val("bank", 14'h3fff - 14'h0123 * i[13:0], bank_out(i));
  endtask

  task automatic t_guard;
    onhook_command_in = 1'b0;
    put_entry(16'h0002, 14'h0001);
    onhook_command_in = 1'b1;
    check_val("offhook write", 14'h3fff, transmit_full_scale_level_out);
    put_entry(16'h0102, 14'h0005);
    check_val("high address", 14'h3fff, transmit_full_scale_level_out);
    put_entry(16'h0002, 14'h0077);
    wr(`DIPA_PORT_LOW_ADDR, 8'h11);
    repeat (2) @(negedge sys_clk_in);
    check_val("low only", 14'h0077, transmit_full_scale_level_out);
    wr(`DIPA_PORT_HIGH_ADDR, 8'h01);
    wr(`DIPA_PORT_LOW_ADDR, 8'h35);
    repeat (2) @(negedge sys_clk_in);
    check_val("pair", 14'h0135, transmit_full_scale_level_out);
  endtask

  task automatic t_views;
    wr(`DIPA_PORT_SELECT_ADDR, `DIPA_VIEW_TONE);
    wr(`DIPA_PORT_LOW_ADDR, 8'hff);
    check_val("tx view", 16'h007f, {touch_tone_digit_out, tone_type_field_out});
    wr(`DIPA_PORT_HIGH_ADDR, 8'hd5);
    check_val("rpt view", 16'h0075, {square_enable_out, cascade_disable_out,
      report_enable_out});
    rd(`DIPA_PORT_SELECT_ADDR);
    check_val("select", 16'h0002, rd_val);
    rd(`DIPA_PORT_HIGH_ADDR);
    check_val("high read", 16'h0000, rd_val);
    wr(`DIPA_PORT_SELECT_ADDR, `DIPA_VIEW_ADDRESS);
    wr(`DIPA_PORT_HIGH_ADDR, 8'h00);
    rd(`DIPA_PORT_LOW_ADDR);
    check_val("addr read", 16'h0000, rd_val);
    check_val("rpt kept", 16'h0015, report_enable_out);
  endtask

  task automatic t_status;
    wr(`DIPA_PORT_SELECT_ADDR, `DIPA_VIEW_TONE);
    wr(`DIPA_PORT_HIGH_ADDR, 8'h1f);
    tone_hits_in = 5'h03;
    touch_digit_in = 4'h5;
    repeat (3) @(negedge sys_clk_in);
    rd(`DIPA_PORT_LOW_ADDR);
    check_val("priority", 16'h00c1, rd_val);
    wr(`DIPA_PORT_HIGH_ADDR, 8'h01);
    repeat (3) @(negedge sys_clk_in);
    rd(`DIPA_PORT_LOW_ADDR);
    check_val("enabled only", 16'h00d5, rd_val);
    wr(`DIPA_PORT_HIGH_ADDR, 8'h04);
    repeat (3) @(negedge sys_clk_in);
    rd(`DIPA_PORT_LOW_ADDR);
    // Flag set again after the last read while touch-tone was still enabled
    check_val("masked", 16'h0095, rd_val);
    tone_hits_in = 5'h00;
  endtask

  task automatic t_tone;
    put_entry(`DIPA_USER_TONE_FREQUENCY, 14'h01f0);
    put_entry(`DIPA_TONE_GENERATION_LEVEL, 14'h0123);
    wr(`DIPA_PORT_SELECT_ADDR, `DIPA_VIEW_TONE);
    wr(`DIPA_PORT_LOW_ADDR, 8'h06);
    repeat (3) @(negedge sys_clk_in);
    check_val("tone on", 16'h4123, {user_tone_active_out, user_tone_amplitude_out});
    repeat (3) begin
      @(negedge sys_clk_in);
      sample_tick_in = 1'b1;
      @(negedge sys_clk_in);
      sample_tick_in = 1'b0;
    end
    check_val("phase", 16'h01d0, user_tone_phase_out);
    wr(`DIPA_PORT_LOW_ADDR, 8'h00);
    repeat (3) @(negedge sys_clk_in);
    check_val("tone off phase", 16'h0000, {7'h00, user_tone_phase_out});
    check_val("tone off amp", 16'h0000, {2'b00, user_tone_amplitude_out});
  endtask

  task automatic t_hyst;
    logic [13:0] lvl [4] = '{14'h0900, 14'h0600, 14'h0300, 14'h0600};
    logic [1:0]  exp [4] = '{2'b11, 2'b11, 2'b00, 2'b00};
    put_entry(`DIPA_CARRIER_ON_THRESHOLD, 14'h0800);
    put_entry(`DIPA_CARRIER_OFF_THRESHOLD, 14'h0400);
    put_entry(`DIPA_ANSWER_ON_THRESHOLD, 14'h0800);
    put_entry(`DIPA_ANSWER_OFF_THRESHOLD, 14'h0400);
    for (int i = 0; i < 4; i++) begin
      carrier_level_in = lvl[i];
      answer_level_in = lvl[i];
      repeat (3) @(negedge sys_clk_in);
      check_val("valid flags", exp[i], {carrier_valid_out, answer_valid_out});
    end
  endtask

  initial begin
    repeat (16) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    t_reset;
    t_bank;
    t_guard;
    t_views;
    t_status;
    t_tone;
    t_hyst;
    sys_rst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    t_reset;
    give_verdict;
  end
endmodule
